/* pkg/sac_cfg.svh */
// Constants of the successive-approximation converter control block.
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ****************************************************************
// Channel codes.
// ****************************************************************
`define SAC_CH_EXT_LAST  5'h0f
`define SAC_CH_TEMP      5'h1a
`define SAC_CH_BANDGAP   5'h1b
`define SAC_CH_RSVD      5'h1c
`define SAC_CH_REFH      5'h1d
`define SAC_CH_REFL      5'h1e
`define SAC_CH_OFF       5'h1f

// ****************************************************************
// Clock sources and result modes.
// ****************************************************************
`define SAC_SRC_BUS      2'h0
`define SAC_SRC_BUS_HALF 2'h1
`define SAC_SRC_LOCAL    2'h2
`define SAC_SRC_ALT      2'h3
`define SAC_MODE_8       2'h0
`define SAC_MODE_12      2'h1
`define SAC_MODE_10      2'h2

// ****************************************************************
// Last sampling tick counts (sampling length in conversion clock ticks minus one), and SAR constants.
// ****************************************************************
`define SAC_SAMP_SHORT   5'h03
`define SAC_SAMP_LONG    5'h17
`define SAC_SAR_MSB      12'h800
`define SAC_BIT_TOP      4'hb

`endif

/* pkg/sac_pkg.sv */
// Types shared by the converter control block.
package sac_pkg;

  typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_CONVERT} sac_state_t;

  // Fields written together by a write of the first control register.
  typedef struct packed {
    logic       int_en;
    logic       cont_en;
    logic [4:0] channel;
  } sac_ctrl1_t;

  // Static configuration bits.
  typedef struct packed {
    logic       trig_hw;
    logic       cmp_en;
    logic       cmp_gte;
    logic [1:0] mode;
    logic [1:0] clk_src;
    logic [1:0] clk_div;
    logic       long_sample;
    logic       low_power;
  } sac_cfg_t;

  // Analog multiplexer selects.
  typedef struct packed {
    logic [15:0] ext;
    logic        temp;
    logic        bandgap;
    logic        refh;
    logic        refl;
  } sac_mux_t;

endpackage

/* verilog/sac_clk_gen.sv */
// Conversion clock source selection and division into a tick.
`timescale 1ns/10ps
`include "sac_cfg.svh"
module sac_clk_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] clk_src,
  input  wire logic [1:0] clk_div,
  input  wire logic       stop3_mode,
  input  wire logic       stop2_mode,
  input  wire logic       local_async_conv_clock,
  input  wire logic       alternate_clock_input,
  output logic            tick
);

  logic       async_s1_r, async_s2_r, async_s3_r;
  logic       alt_d_r;
  logic       half_r, half_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] limit;
  logic       tick_r, tick_nxt;
  logic       src_ev;

  // ****************************************************************
  // Source event select and divider.
  // ****************************************************************
  // Bus sources stop in stop3, while the local clock keeps converting there.
  always_comb begin
    half_nxt = ~half_r;
    limit    = 3'((4'h1 << clk_div) - 4'h1);
    case (clk_src)
      `SAC_SRC_BUS:      src_ev = ~stop3_mode & ~stop2_mode;
      `SAC_SRC_BUS_HALF: src_ev = half_r & ~stop3_mode & ~stop2_mode;
      `SAC_SRC_LOCAL:    src_ev = async_s2_r & ~async_s3_r & ~stop2_mode;
      `SAC_SRC_ALT:      src_ev = alternate_clock_input & ~alt_d_r
                                  & ~stop3_mode & ~stop2_mode;
      default:           src_ev = 1'b0;
    endcase
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (src_ev) begin
      tick_nxt = (cnt_r == limit);
      cnt_nxt  = (cnt_r == limit) ? 3'h0 : 3'(cnt_r + 3'h1);
    end
  end

  // ****************************************************************
  // Registers; the local clock passes two flops before edge detection.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      async_s1_r <= 1'b0;
      async_s2_r <= 1'b0;
      async_s3_r <= 1'b0;
      alt_d_r    <= 1'b0;
      half_r     <= 1'b0;
      cnt_r      <= 3'h0;
      tick_r     <= 1'b0;
    end else begin
      async_s1_r <= local_async_conv_clock;
      async_s2_r <= async_s1_r;
      async_s3_r <= async_s2_r;
      alt_d_r    <= alternate_clock_input;
      half_r     <= half_nxt;
      cnt_r      <= cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign tick = tick_r;

  chk_alt_stop_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_src == `SAC_SRC_ALT && (stop3_mode || stop2_mode)) |=> !tick_r)
    else $error("Alternate clock produced a tick in stop.");

endmodule

/* verilog/sac_ctrl.sv */
// Successive-approximation converter control: start, SAR sequence, result, flags.
`timescale 1ns/10ps
`include "sac_cfg.svh"
module sac_ctrl (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ctrl_write,
  input  wire sac_pkg::sac_ctrl1_t ctrl_wdata,
  input  wire sac_pkg::sac_cfg_t  cfg,
  input  wire logic [11:0]        compare_value,
  input  wire logic               result_low_read,
  input  wire logic               hw_trigger_input,
  input  wire logic               stop3_mode,
  input  wire logic               stop2_mode,
  input  wire logic               local_async_conv_clock,
  input  wire logic               alternate_clock_input,
  input  wire logic               cmp_in,
  output sac_pkg::sac_mux_t       mux_sel,
  output logic                    conv_power_on,
  output logic                    sample_hold,
  output logic [11:0]             dac_code,
  output logic                    low_power_out,
  output logic [11:0]             result,
  output logic                    conversion_done_flag,
  output logic                    conversion_active_flag,
  output logic                    conv_irq
);

  sac_pkg::sac_state_t state_r, state_nxt;
  sac_pkg::sac_ctrl1_t ctl_r, ctl_nxt;
  sac_pkg::sac_mux_t   mux_r, mux_nxt;
  logic [4:0]          cnt_r, cnt_nxt;
  logic [3:0]          bit_r, bit_nxt;
  logic [11:0]         sar_r, sar_nxt;
  logic [11:0]         res_r, res_nxt;
  logic                done_r, done_nxt;
  logic                act_r, act_nxt;
  logic                irq_r, irq_nxt;
  logic                pwr_r, pwr_nxt;
  logic                samp_r, samp_nxt;
  logic                lp_r, lp_nxt;
  logic                hwt_d_r;
  logic                tick;
  logic                hw_edge;
  logic                fin;
  logic                hit;
  logic [11:0]         raw;
  logic [11:0]         fmt;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Channel decode to multiplexer selects; reserved codes select nothing,
  // so the conversion still runs but its value carries no meaning.
  function automatic sac_pkg::sac_mux_t mux_decode(input logic [4:0] ch);
    sac_pkg::sac_mux_t m;
    m = '0;
    if (ch <= `SAC_CH_EXT_LAST) begin
      m.ext = 16'h0001 << ch[3:0];
    end
    m.temp    = (ch == `SAC_CH_TEMP);
    m.bandgap = (ch == `SAC_CH_BANDGAP);
    m.refh    = (ch == `SAC_CH_REFH);
    m.refl    = (ch == `SAC_CH_REFL);
    return m;
  endfunction

  // Right-justified unsigned formatting of the twelve-bit raw value.
  function automatic logic [11:0] fmt_result(input logic [1:0] mode, input logic [11:0] v);
    case (mode)
      `SAC_MODE_12: fmt_result = v;
      `SAC_MODE_10: fmt_result = {2'h0, v[11:2]};
      default:      fmt_result = {4'h0, v[11:4]};
    endcase
  endfunction

  sac_clk_gen u_clk_gen (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .clk_src                (cfg.clk_src),
    .clk_div                (cfg.clk_div),
    .stop3_mode             (stop3_mode),
    .stop2_mode             (stop2_mode),
    .local_async_conv_clock (local_async_conv_clock),
    .alternate_clock_input  (alternate_clock_input),
    .tick                   (tick)
  );

  // Trigger edge and end-of-conversion terms.
  // The trigger is a plain edge detect, so it starts a run in any low-power state; in stop2 no source ticks until stop2 ends.
  assign hw_edge = hw_trigger_input & ~hwt_d_r;
  assign fin     = (state_r == sac_pkg::SAC_CONVERT) && tick && (bit_r == 4'h0);
  assign raw     = cmp_in ? sar_r : (sar_r & ~(12'h001 << bit_r));
  assign fmt     = fmt_result(cfg.mode, raw);
  assign hit     = ~cfg.cmp_en | (cfg.cmp_gte ? (fmt >= compare_value)
                                              : (fmt < compare_value));

  // ****************************************************************
  // Conversion sequencer next state.
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    ctl_nxt   = ctl_r;
    cnt_nxt   = cnt_r;
    bit_nxt   = bit_r;
    sar_nxt   = sar_r;
    res_nxt   = res_r;
    case (state_r)
      sac_pkg::SAC_IDLE: begin
        if (cfg.trig_hw && hw_edge && ctl_r.channel != `SAC_CH_OFF) begin
          state_nxt = sac_pkg::SAC_SAMPLE;
          cnt_nxt   = 5'h00;
        end
      end
      sac_pkg::SAC_SAMPLE: begin
        if (tick) begin
          cnt_nxt = 5'(cnt_r + 5'h01);
          if (cnt_r == (cfg.long_sample ? `SAC_SAMP_LONG : `SAC_SAMP_SHORT)) begin
            state_nxt = sac_pkg::SAC_CONVERT;
            sar_nxt   = `SAC_SAR_MSB;
            bit_nxt   = `SAC_BIT_TOP;
          end
        end
      end
      sac_pkg::SAC_CONVERT: begin
        if (tick) begin
          sar_nxt = raw;
          if (bit_r != 4'h0) begin
            bit_nxt = 4'(bit_r - 4'h1);
            sar_nxt = raw | (12'h001 << bit_nxt);
          end else begin
            if (hit) begin
              res_nxt = fmt;
            end
            cnt_nxt = 5'h00;
            // Continuous mode re-samples; single mode drops back to idle.
            state_nxt = ctl_r.cont_en ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
          end
        end
      end
      default: state_nxt = sac_pkg::SAC_IDLE;
    endcase
    // A control write wins over the state and count: abort, then restart if enabled.
    if (ctrl_write) begin
      ctl_nxt   = ctrl_wdata;
      cnt_nxt   = 5'h00;
      state_nxt = (ctrl_wdata.channel != `SAC_CH_OFF && !cfg.trig_hw)
                  ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
    end
  end

  // ****************************************************************
  // Flags and analog-facing outputs next values.
  // ****************************************************************
  // A completion in the same cycle as a clearing access keeps the flag set.
  always_comb begin
    done_nxt = (fin && hit) | (done_r & ~ctrl_write & ~result_low_read);
    act_nxt  = (state_nxt != sac_pkg::SAC_IDLE);
    irq_nxt  = done_nxt & ctl_nxt.int_en;
    mux_nxt  = mux_decode(ctl_nxt.channel);
    pwr_nxt  = act_nxt;
    samp_nxt = (state_nxt == sac_pkg::SAC_SAMPLE);
    lp_nxt   = cfg.low_power;
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sac_pkg::SAC_IDLE;
      ctl_r   <= '{int_en: 1'b0, cont_en: 1'b0, channel: `SAC_CH_OFF};
      mux_r   <= '0;
      cnt_r   <= 5'h00;
      bit_r   <= 4'h0;
      sar_r   <= 12'h000;
      res_r   <= 12'h000;
      done_r  <= 1'b0;
      act_r   <= 1'b0;
      irq_r   <= 1'b0;
      pwr_r   <= 1'b0;
      samp_r  <= 1'b0;
      lp_r    <= 1'b0;
      hwt_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctl_r   <= ctl_nxt;
      mux_r   <= mux_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      sar_r   <= sar_nxt;
      res_r   <= res_nxt;
      done_r  <= done_nxt;
      act_r   <= act_nxt;
      irq_r   <= irq_nxt;
      pwr_r   <= pwr_nxt;
      samp_r  <= samp_nxt;
      lp_r    <= lp_nxt;
      hwt_d_r <= hw_trigger_input;
    end
  end

  // Outputs straight from flops.
  assign mux_sel                = mux_r;
  assign conv_power_on          = pwr_r;
  assign sample_hold            = samp_r;
  assign dac_code               = sar_r;
  assign low_power_out          = lp_r;
  assign result                 = res_r;
  assign conversion_done_flag   = done_r;
  assign conversion_active_flag = act_r;
  assign conv_irq               = irq_r;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_write_restart: assert property (
    ctrl_write && ctrl_wdata.channel != `SAC_CH_OFF && !cfg.trig_hw
    |=> state_r == sac_pkg::SAC_SAMPLE && cnt_r == 5'h00 && conversion_active_flag)
    else $error("Control write did not restart sampling.");

  chk_off_stays_idle: assert property (
    ctrl_write && ctrl_wdata.channel == `SAC_CH_OFF
    |=> !conversion_active_flag && !conv_power_on)
    else $error("Disabled channel code left converter active.");

  chk_active_span: assert property (
    state_r != sac_pkg::SAC_IDLE |-> conversion_active_flag && conv_power_on)
    else $error("Active flag low during a conversion.");

  chk_done_clear: assert property (
    (ctrl_write || result_low_read) && !fin |=> !conversion_done_flag)
    else $error("Done flag survived a clearing access.");

  chk_done_wins: assert property (
    fin && hit |=> conversion_done_flag ##0 (conv_irq == ctl_r.int_en))
    else $error("Completion did not set done and interrupt.");

  chk_hw_start: assert property (
    state_r == sac_pkg::SAC_IDLE && cfg.trig_hw && hw_edge && !ctrl_write
    && ctl_r.channel != `SAC_CH_OFF |=> state_r == sac_pkg::SAC_SAMPLE)
    else $error("Hardware trigger did not start a conversion.");

  chk_fmt_eight: assert property (
    fin && hit && cfg.mode == `SAC_MODE_8 |=> result[11:8] == 4'h0)
    else $error("Eight-bit result not right-justified.");

  chk_cmp_gate: assert property (
    fin && !hit && !done_r |=> !conversion_done_flag && $stable(result))
    else $error("Failed compare set the done flag.");

  chk_single_idle: assert property (
    fin && !ctl_r.cont_en && !ctrl_write |=> state_r == sac_pkg::SAC_IDLE)
    else $error("Single conversion did not return to idle.");

  chk_sample_short: assert property (
    state_r == sac_pkg::SAC_SAMPLE && tick && cnt_r == `SAC_SAMP_SHORT && !cfg.long_sample
    && !ctrl_write |=> state_r == sac_pkg::SAC_CONVERT && dac_code == `SAC_SAR_MSB)
    else $error("Short sample did not start the search at the top bit.");

  chk_sample_long: assert property (
    state_r == sac_pkg::SAC_SAMPLE && tick && cnt_r == `SAC_SAMP_SHORT && cfg.long_sample
    && !ctrl_write |=> state_r == sac_pkg::SAC_SAMPLE)
    else $error("Long sample ended after the short length.");

  chk_bit_walk: assert property (
    state_r == sac_pkg::SAC_CONVERT && tick && bit_r != 4'h0 && !ctrl_write
    |=> bit_r == 4'($past(bit_r) - 4'h1))
    else $error("Search did not step down one bit per tick.");

  chk_mux_onehot: assert property (
    $onehot0(mux_sel))
    else $error("More than one analog source selected.");

  chk_reserved_runs: assert property (
    ctrl_write && ctrl_wdata.channel == `SAC_CH_RSVD && !cfg.trig_hw
    |=> conversion_active_flag && mux_sel == '0)
    else $error("Reserved channel did not run with no source selected.");

  chk_done_sticky: assert property (
    conversion_done_flag && !ctrl_write && !result_low_read |=> conversion_done_flag)
    else $error("Done flag dropped without a clearing access.");

  chk_cont_resample: assert property (
    fin && ctl_r.cont_en && !ctrl_write |=> state_r == sac_pkg::SAC_SAMPLE && sample_hold)
    else $error("Continuous mode did not sample again.");

  chk_hw_write_idle: assert property (
    ctrl_write && cfg.trig_hw |=> state_r == sac_pkg::SAC_IDLE && !conversion_active_flag)
    else $error("Write started a conversion in hardware trigger mode.");

  chk_hw_busy_ignored: assert property (
    state_r != sac_pkg::SAC_IDLE && hw_edge && !fin && !ctrl_write
    |=> state_r != sac_pkg::SAC_IDLE)
    else $error("Trigger edge during a conversion disturbed it.");

  chk_result_hold: assert property (
    !(fin && hit) |=> $stable(result))
    else $error("Result changed outside a completed hit.");

  cov_single_done: cover property (fin && hit && !ctl_r.cont_en);
  cov_continuous: cover property (fin && ctl_r.cont_en ##1 state_r == sac_pkg::SAC_SAMPLE);
  cov_hw_trigger: cover property (cfg.trig_hw && hw_edge && state_r == sac_pkg::SAC_IDLE);
  cov_cmp_miss: cover property (fin && !hit);
  cov_reserved_run: cover property (fin && mux_r == '0);

endmodule

/* sim/sac_analog_model.sv */
// Behavioural analog multiplexer and comparator on the far side of the control.
`timescale 1ns/10ps
module sac_analog_model (
  input  wire logic              clk,
  input  wire sac_pkg::sac_mux_t mux_sel,
  input  wire logic              sample_hold,
  input  wire logic              conv_power_on,
  input  wire logic [11:0]       dac_code,
  output logic                   cmp_in
);
  logic [11:0] held_r;
  logic        noise_r;
  logic [11:0] level;

  // ****************************************************************
  // Source levels and comparator.
  // ****************************************************************
  // Level of the selected source; nothing selected floats and reads as noise.
  always_comb begin
    level = {11'h000, noise_r};
    for (int i = 0; i < 16; i++) begin
      if (mux_sel.ext[i]) begin
        level = {i[3:0], 8'h5a};
      end
    end
    if (mux_sel.temp) level = 12'h3c7;
    if (mux_sel.bandgap) level = 12'h5e1;
    if (mux_sel.refh) level = 12'hfff;
    if (mux_sel.refl) level = 12'h000;
  end

  // The capacitor tracks while sampling and holds during the search.
  always @(posedge clk) begin
    noise_r <= ~noise_r;
    if (sample_hold) held_r <= level;
  end

  // An unpowered comparator gives a changing pattern, never a steady answer.
  assign cmp_in = conv_power_on ? (held_r >= dac_code) : noise_r;

  initial noise_r = 1'b0;
endmodule

/* sim/sac_ctrl_bench.sv */
// Self-checking bench of the converter control against the analog model.
`timescale 1ns/10ps
`include "sac_cfg.svh"
module sac_ctrl_bench;
  logic clk, rst_n, ctrl_write, result_low_read, hw_trigger_input;
  logic stop3_mode, stop2_mode, local_clk, alt_clk, cmp_in;
  sac_pkg::sac_ctrl1_t ctrl_wdata;
  sac_pkg::sac_cfg_t   cfg;
  sac_pkg::sac_mux_t   mux_sel;
  logic [11:0] compare_value, dac_code, result;
  logic conv_power_on, sample_hold, low_power_out, done, active, conv_irq;
  int fails, samples_checked, c, cs, cl;
  logic [4:0] chans [7] = '{5'h00, 5'h09, 5'h0f, 5'h1d, 5'h1e, 5'h1c, 5'h10};

  sac_ctrl u_sac_ctrl (.clk(clk), .rst_n(rst_n), .ctrl_write(ctrl_write),
    .ctrl_wdata(ctrl_wdata), .cfg(cfg), .compare_value(compare_value),
    .result_low_read(result_low_read), .hw_trigger_input(hw_trigger_input),
    .stop3_mode(stop3_mode), .stop2_mode(stop2_mode),
    .local_async_conv_clock(local_clk), .alternate_clock_input(alt_clk),
    .cmp_in(cmp_in), .mux_sel(mux_sel), .conv_power_on(conv_power_on),
    .sample_hold(sample_hold), .dac_code(dac_code), .low_power_out(low_power_out),
    .result(result), .conversion_done_flag(done),
    .conversion_active_flag(active), .conv_irq(conv_irq));

  sac_analog_model u_sac_analog_model (.clk(clk), .mux_sel(mux_sel),
    .sample_hold(sample_hold), .conv_power_on(conv_power_on),
    .dac_code(dac_code), .cmp_in(cmp_in));

  // ****************************************************************
  // Clocks.
  // ****************************************************************
  // Bus clock and a free local clock of unrelated phase.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    local_clk = 1'b0;
    #7;
    forever #30 local_clk = ~local_clk;
  end
  // Generator reference clock at a quarter of the bus rate.
  initial alt_clk = 1'b0;
  always @(negedge clk) alt_clk <= $time % 160 < 80;

  // ****************************************************************
  // Compare, access and reporting tasks.
  // ****************************************************************
  task automatic chk_word(string what, logic [19:0] exp, logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(string what, logic exp, logic got);
    chk_word(what, {19'h0, exp}, {19'h0, got});
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic write_ctrl(logic ie, logic co, logic [4:0] ch);
    @(negedge clk);
    ctrl_write = 1'b1;
    ctrl_wdata = '{ie, co, ch};
    @(negedge clk);
    ctrl_write = 1'b0;
  endtask

  task automatic rd_low();
    @(negedge clk);
    result_low_read = 1'b1;
    @(negedge clk);
    result_low_read = 1'b0;
  endtask

  // Bounded wait so a lost completion shows as a mismatch, not a hang.
  task automatic wait_done(output int cyc);
    cyc = 0;
    while (done !== 1'b1 && cyc < 6000) begin
      @(negedge clk);
      cyc++;
    end
    chk_bit("done arrived", 1'b1, done);
  endtask

  function automatic logic [11:0] lvl(logic [4:0] ch);
    case (ch)
      `SAC_CH_TEMP:    lvl = 12'h3c7;
      `SAC_CH_BANDGAP: lvl = 12'h5e1;
      `SAC_CH_REFH:    lvl = 12'hfff;
      `SAC_CH_REFL:    lvl = 12'h000;
      default:         lvl = {ch[3:0], 8'h5a};
    endcase
  endfunction

  function automatic logic [19:0] mx(logic [4:0] ch);
    if (ch <= 5'h0f) mx = 20'h0_0010 << ch;
    else if (ch == `SAC_CH_TEMP) mx = 20'h0_0008;
    else if (ch == `SAC_CH_BANDGAP) mx = 20'h0_0004;
    else if (ch == `SAC_CH_REFH) mx = 20'h0_0002;
    else if (ch == `SAC_CH_REFL) mx = 20'h0_0001;
    else mx = 20'h0_0000;
  endfunction

  function automatic logic [11:0] fmt(logic [11:0] v);
    fmt = (cfg.mode == `SAC_MODE_12) ? v : (cfg.mode == `SAC_MODE_10) ? v >> 2 : v >> 4;
  endfunction

  // One single conversion with its flags, routing and formatted result.
  task automatic conv(logic [4:0] ch, logic ie, output int cyc);
    write_ctrl(ie, 1'b0, ch);
    chk_bit("done cleared by write", 1'b0, done);
    @(negedge clk);
    chk_bit("active at start", 1'b1, active);
    chk_bit("sampling at start", 1'b1, sample_hold);
    chk_bit("power at start", 1'b1, conv_power_on);
    wait_done(cyc);
    chk_word("routing", mx(ch), mux_sel);
    if (mx(ch) !== 20'h0) chk_word("result", {8'h0, fmt(lvl(ch))}, {8'h0, result});
    if (mx(ch) !== 20'h0) chk_word("final trial", {8'h0, lvl(ch)}, {8'h0, dac_code});
    chk_bit("irq", ie, conv_irq);
    chk_bit("idle after single", 1'b0, active);
    chk_bit("power off after single", 1'b0, conv_power_on);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {rst_n, ctrl_write, result_low_read, hw_trigger_input, stop3_mode, stop2_mode} = '0;
    ctrl_wdata = '0;
    cfg = '0;
    cfg.mode = `SAC_MODE_12;
    compare_value = 12'h000;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk_bit("active after reset", 1'b0, active);
    foreach (chans[i]) conv(chans[i], i[0], cs);
    rd_low();
    chk_bit("done cleared by low read", 1'b0, done);
    cfg.mode = `SAC_MODE_10;
    conv(5'h0f, 1'b0, c);
    cfg.mode = `SAC_MODE_8;
    conv(5'h0f, 1'b0, c);
    cfg.mode = `SAC_MODE_12;
    cfg.low_power = 1'b1;
    cfg.long_sample = 1'b1;
    conv(`SAC_CH_BANDGAP, 1'b0, cl);
    conv(`SAC_CH_TEMP, 1'b0, c);
    chk_word("long sample extra", 20'd20, 20'(cl - cs));
    chk_bit("power setting", 1'b1, low_power_out);
    cfg.long_sample = 1'b0;
    for (int s = 0; s < 4; s++) begin
      cfg.clk_src = s[1:0];
      cfg.clk_div = s[1:0];
      conv(5'h07, 1'b0, c);
      // Sixteen ticks; the count starts one cycle after the start edge.
      chk_bit("divided rate", 1'b1, c >= (15 << s));
    end
    // Alternate source is stopped in stop3; the run resumes afterwards.
    cfg.clk_src = `SAC_SRC_ALT;
    cfg.clk_div = 2'h0;
    stop3_mode = 1'b1;
    write_ctrl(1'b0, 1'b0, 5'h02);
    repeat (200) @(negedge clk);
    chk_bit("no alt ticks in stop3", 1'b0, done);
    stop3_mode = 1'b0;
    wait_done(c);
    cfg.clk_src = `SAC_SRC_LOCAL;
    stop2_mode = 1'b1;
    write_ctrl(1'b0, 1'b0, 5'h02);
    repeat (200) @(negedge clk);
    chk_bit("no ticks in stop2", 1'b0, done);
    stop2_mode = 1'b0;
    wait_done(c);
    // Hardware start in stop3 on the local clock.
    stop3_mode = 1'b1;
    cfg.trig_hw = 1'b1;
    write_ctrl(1'b0, 1'b0, 5'h03);
    @(negedge clk);
    chk_bit("write does not start", 1'b0, active);
    hw_trigger_input = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit("hw start", 1'b1, active);
    // A second trigger edge while busy must be ignored.
    hw_trigger_input = 1'b0;
    @(negedge clk);
    hw_trigger_input = 1'b1;
    wait_done(c);
    chk_word("hw result", {8'h0, lvl(5'h03)}, {8'h0, result});
    {hw_trigger_input, stop3_mode, cfg.trig_hw} = '0;
    cfg.clk_src = `SAC_SRC_BUS;
    write_ctrl(1'b0, 1'b0, 5'h05);
    repeat (5) @(negedge clk);
    write_ctrl(1'b0, 1'b0, 5'h06);
    chk_bit("active over restart", 1'b1, active);
    wait_done(c);
    chk_word("restart result", {8'h0, lvl(5'h06)}, {8'h0, result});
    // Compare miss, then less-than and greater-or-equal hits.
    cfg.cmp_en = 1'b1;
    cfg.cmp_gte = 1'b1;
    compare_value = 12'hfff;
    write_ctrl(1'b0, 1'b0, `SAC_CH_REFL);
    repeat (60) @(negedge clk);
    chk_bit("miss no done", 1'b0, done);
    chk_word("miss keeps result", {8'h0, lvl(5'h06)}, {8'h0, result});
    cfg.cmp_gte = 1'b0;
    compare_value = 12'h001;
    conv(`SAC_CH_REFL, 1'b1, c);
    cfg.cmp_gte = 1'b1;
    compare_value = 12'h800;
    conv(`SAC_CH_REFH, 1'b1, c);
    cfg.cmp_en = 1'b0;
    // Continuous runs until the channel is switched off.
    write_ctrl(1'b0, 1'b1, 5'h03);
    wait_done(c);
    rd_low();
    wait_done(c);
    chk_bit("still running", 1'b1, active);
    write_ctrl(1'b0, 1'b0, `SAC_CH_OFF);
    repeat (40) @(negedge clk);
    chk_bit("off stops", 1'b0, active);
    chk_bit("off no done", 1'b0, done);
    chk_word("off routing", 20'h0, mux_sel);
    close_out();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (80000) @(negedge clk);
    fails++;
    close_out();
  end
endmodule
